// ---- include/tmr_map.svh ----
// Operation
// R01: each channel has a mode bit at odd position, level bit just below it
// R02: on compare, 00 disconnects, 01 toggles, 10 clears, 11 sets the line
// R03: nonzero mode or level makes the channel pin an output of its line
// R04: mode/level action only applies while that pin's channel-3 mask is clear
// R05: two-bit edge select per channel: off, rising, falling, both edges
// R06: channel interrupt raised only while enable bit and event flag are set
// R07: overflow interrupt requested while its enable and the overflow flag are set
// R08: compare-reset enable makes a channel 3 compare zero the counter
// R09: channel 3 value zero with compare-reset enabled holds counter at zero
// R10: compare reset from all ones to zero never sets the overflow flag
// R11: prescale select 0..7 divides the bus clock by 1 to 128
// R12: new prescale selection applies only when the prescale counter is zero
// R13: channel flag set by capture or compare event, sticky until cleared
// R14: write one clears a flag; fast clear also clears on capture read/compare write
// R15: counter wrap from all ones to zero sets overflow flag, write one clears
// R16: channel 3 compare overrides others; masked pins take the channel-3 value bits
// R17: counter steps once per tick; compare when counter equals value in compare mode
// R18: unused upper bits of enable, flag and control registers read zero
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

// register offsets
`define TMR_ADDR_IO_SELECT 8'hc0
`define TMR_ADDR_C3_MASK 8'hc2
`define TMR_ADDR_C3_VALUE 8'hc3
`define TMR_ADDR_CNT_HI 8'hc4
`define TMR_ADDR_CNT_LO 8'hc5
`define TMR_ADDR_SYS_FIRST 8'hc6
`define TMR_ADDR_OUT_ACT 8'hc8
`define TMR_ADDR_EDGE_CTL 8'hc9
`define TMR_ADDR_IRQ_EN 8'hca
`define TMR_ADDR_SYS_SECOND 8'hcb
`define TMR_ADDR_FLAGS 8'hcc
`define TMR_ADDR_OVF_FLAG 8'hcd
`define TMR_ADDR_TC_FIRST 8'hce
`define TMR_ADDR_TC_LAST 8'hd5

// field positions
`define TMR_OVF_IRQ_EN_BIT 7
`define TMR_CMP_RST_EN_BIT 3
`define TMR_FFC_BIT 4
`define TMR_OVF_FLAG_BIT 7

// reset and fixed values
`define TMR_RST_BYTE 8'h00
`define TMR_CNT_ZERO 16'h0000
`define TMR_CNT_MAX 16'hffff
`define TMR_PSC_ZERO 7'h00

`endif

// ---- include/tmr_pkg.sv ----
package tmr_pkg;

	// one register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	// software control fields
	typedef struct packed {
		logic [3:0] io_select;
		logic fast_flag_clear;
		logic [3:0] chan3_pin_mask;
		logic [3:0] chan3_pin_value;
		logic [7:0] out_act;
		logic [7:0] edge_ctl;
		logic [3:0] irq_en;
		logic overflow_irq_enable;
		logic compare_reset_enable;
		logic [2:0] prescale_select;
	} ctl_t;

	// state of the timer core, apart from the prescaler and the pin synchronizer
	typedef struct packed {
		ctl_t ctl;
		logic [15:0] cnt;
		logic [3:0][15:0] tc;
		logic [3:0] flags;
		logic counter_overflow_flag;
		logic [3:0] oc;
		logic [3:0] oe;
		logic [3:0] prev;
		logic irq;
		logic [7:0] rdata;
	} tmr_state_t;

	// prescaler state
	typedef struct packed {
		logic [6:0] cnt;
		logic [2:0] sel;
	} psc_state_t;

endpackage

// ---- design/tmr_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_sync (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [3:0] pin_async,
	output logic [3:0] pin_sync
);
	logic [3:0] meta_r;
	logic [3:0] sync_r;

	// two stages; only the second is used downstream
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			meta_r <= 4'h0;
			sync_r <= 4'h0;
		end else begin
			meta_r <= pin_async;
			sync_r <= meta_r;
		end
	end

	assign pin_sync = sync_r;
endmodule
`default_nettype wire

// ---- design/tmr_prescaler.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tmr_map.svh"
module tmr_prescaler (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [2:0] sel_req,
	output logic tick
);
	import tmr_pkg::*;

	psc_state_t st_r;
	psc_state_t st_nxt;

	// low bits of the stage counter that must be zero for a tick
	function automatic logic [6:0] ratio_mask(input logic [2:0] sel);
		ratio_mask = 7'((8'h01 << sel) - 8'h01);
	endfunction

	// free stage counter; selection swaps only at the all-zero point
	always_comb begin
		st_nxt = st_r;
		st_nxt.cnt = 7'(st_r.cnt + 7'h01);
		if (st_r.cnt == `TMR_PSC_ZERO) begin
			st_nxt.sel = sel_req; // R12
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// divide by 2**sel of the bus clock
	assign tick = ((st_r.cnt & ratio_mask(st_r.sel)) == `TMR_PSC_ZERO); // R11

	sel_hold_a: assert property (@(posedge clk_sys) disable iff (srst) // R12
		(st_r.cnt != `TMR_PSC_ZERO) |=> (st_r.sel == $past(st_r.sel)))
		else $error("prescale select changed away from the zero point");
endmodule
`default_nettype wire

// ---- design/tmr_capcmp.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tmr_map.svh"
module tmr_capcmp (
	input wire logic clk_sys,
	input wire logic srst,
	input wire tmr_pkg::bus_req_t bus_req,
	output logic [7:0] rd_data,
	output logic irq,
	input wire logic [3:0] timer_port_pin_in,
	output logic [3:0] timer_port_pin_out,
	output logic [3:0] timer_port_pin_oe
);
	import tmr_pkg::*;

	tmr_state_t st_r;
	tmr_state_t st_nxt;
	logic tick;
	logic [3:0] pin_syn;
	logic [3:0] match;
	logic [3:0] cap;
	logic mod_reset;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// edge detector per channel: low select bit rising, high bit falling
	function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
		input logic now);
		edge_hit = (sel[0] & ~prev & now) | (sel[1] & prev & ~now); // R05
	endfunction

	// compare register decode: {hit, low byte, channel}
	function automatic logic [3:0] tc_dec(input logic [7:0] a);
		logic [7:0] off;
		off = 8'(a - `TMR_ADDR_TC_FIRST);
		tc_dec = {(a >= `TMR_ADDR_TC_FIRST) && (a <= `TMR_ADDR_TC_LAST), off[0], off[2:1]};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// submodules

	tmr_pin_sync u_sync (
		.clk_sys(clk_sys),
		.srst(srst),
		.pin_async(timer_port_pin_in),
		.pin_sync(pin_syn)
	);

	tmr_prescaler u_psc (
		.clk_sys(clk_sys),
		.srst(srst),
		.sel_req(st_r.ctl.prescale_select),
		.tick(tick)
	);

	////////////////////////////////////////////////////////////////////////
	// event detection

	// compares only on a counter tick, captures on any selected synced edge of a capture channel
	always_comb begin
		for (int n = 0; n < 4; n++) begin
			match[n] = tick & st_r.ctl.io_select[n] & (st_r.cnt == st_r.tc[n]); // R17
			cap[n] = ~st_r.ctl.io_select[n] &
				edge_hit(st_r.ctl.edge_ctl[2*n +: 2], st_r.prev[n], pin_syn[n]);
		end
		mod_reset = match[3] & st_r.ctl.compare_reset_enable; // R08
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [3:0] tcd;
		logic [3:0] clr;
		logic tof_clr;
		logic [1:0] act;
		logic cnt_acc;
		st_nxt = st_r;
		tcd = tc_dec(bus_req.addr);
		clr = 4'h0;
		tof_clr = 1'b0;
		act = 2'b00;
		cnt_acc = (bus_req.addr == `TMR_ADDR_CNT_HI) || (bus_req.addr == `TMR_ADDR_CNT_LO);
		st_nxt.prev = pin_syn;

		// register writes; unused upper bits are dropped
		if (bus_req.wr) begin
			unique case (bus_req.addr)
				`TMR_ADDR_IO_SELECT: st_nxt.ctl.io_select = bus_req.wdata[3:0];
				`TMR_ADDR_C3_MASK: st_nxt.ctl.chan3_pin_mask = bus_req.wdata[3:0];
				`TMR_ADDR_C3_VALUE: st_nxt.ctl.chan3_pin_value = bus_req.wdata[3:0];
				`TMR_ADDR_SYS_FIRST: st_nxt.ctl.fast_flag_clear = bus_req.wdata[`TMR_FFC_BIT];
				`TMR_ADDR_OUT_ACT: st_nxt.ctl.out_act = bus_req.wdata;
				`TMR_ADDR_EDGE_CTL: st_nxt.ctl.edge_ctl = bus_req.wdata; // R05
				`TMR_ADDR_IRQ_EN: st_nxt.ctl.irq_en = bus_req.wdata[3:0]; // R18
				`TMR_ADDR_SYS_SECOND: begin
					st_nxt.ctl.overflow_irq_enable = bus_req.wdata[`TMR_OVF_IRQ_EN_BIT];
					st_nxt.ctl.compare_reset_enable = bus_req.wdata[`TMR_CMP_RST_EN_BIT];
					st_nxt.ctl.prescale_select = bus_req.wdata[2:0]; // R12
				end
				`TMR_ADDR_FLAGS: clr = bus_req.wdata[3:0]; // R14
				`TMR_ADDR_OVF_FLAG: tof_clr = bus_req.wdata[`TMR_OVF_FLAG_BIT]; // R15
				default: begin
					// compare value writes, ignored while the channel captures
					if (tcd[3] && st_r.ctl.io_select[tcd[1:0]]) begin
						if (tcd[2]) begin
							st_nxt.tc[tcd[1:0]][7:0] = bus_req.wdata;
						end else begin
							st_nxt.tc[tcd[1:0]][15:8] = bus_req.wdata;
						end
						if (st_r.ctl.fast_flag_clear) begin
							clr[tcd[1:0]] = 1'b1; // R14
						end
					end
				end
			endcase
		end

		// fast clear: capture read clears its flag, counter access clears overflow
		if (st_r.ctl.fast_flag_clear && (bus_req.rd || bus_req.wr)) begin
			if (bus_req.rd && tcd[3] && !st_r.ctl.io_select[tcd[1:0]]) begin
				clr[tcd[1:0]] = 1'b1; // R14
			end
			if (cnt_acc) begin
				tof_clr = 1'b1;
			end
		end

		// free-running counter, modulus reset from channel 3
		if (tick) begin
			if (mod_reset) begin
				st_nxt.cnt = `TMR_CNT_ZERO; // R08 R09
			end else begin
				st_nxt.cnt = 16'(st_r.cnt + 16'h0001); // R17
			end
		end

		// captured count; a capture beats a stale write in the same cycle
		for (int n = 0; n < 4; n++) begin
			if (cap[n]) begin
				st_nxt.tc[n] = st_r.cnt;
			end
		end

		// sticky flags: the set wins over a clear in the same cycle
		st_nxt.flags = (st_r.flags & ~clr) | match | cap; // R13 R14
		st_nxt.counter_overflow_flag = (st_r.counter_overflow_flag & ~tof_clr) |
			(tick & (st_r.cnt == `TMR_CNT_MAX) & ~mod_reset); // R10 R15

		// compare output lines
		for (int n = 0; n < 4; n++) begin
			act = st_r.ctl.out_act[2*n +: 2]; // R01
			if (match[3] && st_r.ctl.chan3_pin_mask[n]) begin
				st_nxt.oc[n] = st_r.ctl.chan3_pin_value[n]; // R16
			end else if (match[n] && !st_r.ctl.chan3_pin_mask[n]) begin // R04
				unique case (act) // R02
					2'b01: st_nxt.oc[n] = ~st_r.oc[n];
					2'b10: st_nxt.oc[n] = 1'b0;
					2'b11: st_nxt.oc[n] = 1'b1;
					2'b00: st_nxt.oc[n] = st_r.oc[n];
				endcase
			end
			// pin drives whenever an action is set up, or a channel-3 takeover on a compare-mode channel
			st_nxt.oe[n] = (st_nxt.ctl.out_act[2*n +: 2] != 2'b00) | // R03
				(st_nxt.ctl.chan3_pin_mask[n] & st_nxt.ctl.io_select[n]);
		end

		// one level interrupt from the next flag values, so it lines up
		st_nxt.irq = (|(st_nxt.flags & st_nxt.ctl.irq_en)) | // R06
			(st_nxt.counter_overflow_flag & st_nxt.ctl.overflow_irq_enable); // R07

		// read data for the following cycle only; unmapped reads give zero
		st_nxt.rdata = `TMR_RST_BYTE;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				`TMR_ADDR_IO_SELECT: st_nxt.rdata = {4'h0, st_r.ctl.io_select};
				`TMR_ADDR_C3_MASK: st_nxt.rdata = {4'h0, st_r.ctl.chan3_pin_mask};
				`TMR_ADDR_C3_VALUE: st_nxt.rdata = {4'h0, st_r.ctl.chan3_pin_value};
				`TMR_ADDR_CNT_HI: st_nxt.rdata = st_r.cnt[15:8];
				`TMR_ADDR_CNT_LO: st_nxt.rdata = st_r.cnt[7:0];
				`TMR_ADDR_SYS_FIRST: st_nxt.rdata = {3'h0, st_r.ctl.fast_flag_clear, 4'h0};
				`TMR_ADDR_OUT_ACT: st_nxt.rdata = st_r.ctl.out_act;
				`TMR_ADDR_EDGE_CTL: st_nxt.rdata = st_r.ctl.edge_ctl;
				`TMR_ADDR_IRQ_EN: st_nxt.rdata = {4'h0, st_r.ctl.irq_en}; // R18
				`TMR_ADDR_SYS_SECOND: st_nxt.rdata = {st_r.ctl.overflow_irq_enable, 3'h0,
					st_r.ctl.compare_reset_enable, st_r.ctl.prescale_select};
				`TMR_ADDR_FLAGS: st_nxt.rdata = {4'h0, st_r.flags}; // R18
				`TMR_ADDR_OVF_FLAG: st_nxt.rdata = {st_r.counter_overflow_flag, 7'h00};
				default: begin
					if (tcd[3]) begin
						st_nxt.rdata = tcd[2] ? st_r.tc[tcd[1:0]][7:0] : st_r.tc[tcd[1:0]][15:8];
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state flops
	assign rd_data = st_r.rdata;
	assign irq = st_r.irq;
	assign timer_port_pin_out = st_r.oc;
	assign timer_port_pin_oe = st_r.oe;

	////////////////////////////////////////////////////////////////////////
	// checks

	pin_drive_a: assert property (@(posedge clk_sys) disable iff (srst) // R03
		(st_r.ctl.out_act[1:0] != 2'b00) |-> timer_port_pin_oe[0])
		else $error("channel 0 pin not driven with an output action set");

	cnt_step_a: assert property (@(posedge clk_sys) disable iff (srst) // R17
		(tick && !mod_reset) |=> (st_r.cnt == 16'($past(st_r.cnt) + 16'h0001)))
		else $error("counter did not step on a tick");

	mod_reset_a: assert property (@(posedge clk_sys) disable iff (srst) // R08
		(tick && match[3] && st_r.ctl.compare_reset_enable) |=> (st_r.cnt == `TMR_CNT_ZERO))
		else $error("channel 3 compare did not reset the counter");

	hold_zero_a: assert property (@(posedge clk_sys) disable iff (srst) // R09
		(st_r.ctl.compare_reset_enable && st_r.ctl.io_select[3] &&
		st_r.tc[3] == `TMR_CNT_ZERO && st_r.cnt == `TMR_CNT_ZERO) |=>
		(st_r.cnt == `TMR_CNT_ZERO))
		else $error("counter left zero under modulus zero");

	no_tof_mod_a: assert property (@(posedge clk_sys) disable iff (srst) // R10
		(mod_reset && !st_r.counter_overflow_flag) |=> !st_r.counter_overflow_flag)
		else $error("overflow flag set by a compare reset");

	tof_wrap_a: assert property (@(posedge clk_sys) disable iff (srst) // R15
		(tick && st_r.cnt == `TMR_CNT_MAX && !mod_reset) |=> st_r.counter_overflow_flag)
		else $error("wrap did not set the overflow flag");

	flag_set_a: assert property (@(posedge clk_sys) disable iff (srst) // R13
		(|(match | cap)) |=> ((st_r.flags & $past(match | cap)) == $past(match | cap)))
		else $error("event did not set its channel flag");

	irq_gate_a: assert property (@(posedge clk_sys) disable iff (srst) // R06
		irq == ((|(st_r.flags & st_r.ctl.irq_en)) | (st_r.counter_overflow_flag & st_r.ctl.overflow_irq_enable)))
		else $error("interrupt level disagrees with flags and enables");

	toggle_ch0_a: assert property (@(posedge clk_sys) disable iff (srst) // R02
		(match[0] && !match[3] && !st_r.ctl.chan3_pin_mask[0] && st_r.ctl.out_act[1:0] == 2'b01)
		|=> (timer_port_pin_out[0] != $past(timer_port_pin_out[0])))
		else $error("toggle action did not invert channel 0 line");

	mask_override_a: assert property (@(posedge clk_sys) disable iff (srst) // R16
		(match[3] && st_r.ctl.chan3_pin_mask[1]) |=>
		(timer_port_pin_out[1] == $past(st_r.ctl.chan3_pin_value[1])))
		else $error("masked pin did not take the channel 3 value");
endmodule
`default_nettype wire

// ---- test/pin_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
// far side of the timer port: an external driver on each pin
module pin_partner (
	input wire logic [3:0] ext_level,
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe,
	output logic [3:0] pin_level
);
	// a pin the timer drives shows its line; the external driver yields there
	assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	import tmr_pkg::*;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} row_t;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	bus_req_t req = '0;
	logic [7:0] rd_data;
	logic irq;
	logic [3:0] pin_in;
	logic [3:0] pin_out;
	logic [3:0] pin_oe;
	logic [3:0] ext_level = 4'h0;
	logic [7:0] q;
	logic [7:0] q2;
	logic p;
	int err_total = 0;
	int n_checks = 0;
	// address, value written, value read back
	row_t rows [8] = '{
		'{8'hc9, 8'ha5, 8'ha5},
		'{8'hca, 8'hff, 8'h0f},
		'{8'hcb, 8'hff, 8'h8f},
		'{8'hcc, 8'hff, 8'h00},
		'{8'hc8, 8'h5a, 8'h5a},
		'{8'he0, 8'hff, 8'h00},
		'{8'hc2, 8'hff, 8'h0f},
		'{8'hc6, 8'hff, 8'h10}
	};

	////////////////////////////////////////////////////////////////////////////
	// 200 MHz system clock
	always #2.5 clk_sys = ~clk_sys;

	tmr_capcmp i_tmr_capcmp (
		.clk_sys(clk_sys),
		.srst(srst),
		.bus_req(req),
		.rd_data(rd_data),
		.irq(irq),
		.timer_port_pin_in(pin_in),
		.timer_port_pin_out(pin_out),
		.timer_port_pin_oe(pin_oe)
	);

	pin_partner i_pin_partner (
		.ext_level(ext_level),
		.pin_out(pin_out),
		.pin_oe(pin_oe),
		.pin_level(pin_in)
	);

	////////////////////////////////////////////////////////////////////////////
	// bus cycles; idle cycle after each so a strobe is never set twice at one edge
	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		req <= '0;
		@(posedge clk_sys);
	endtask

	// read data stands only in the cycle after the strobe, so take it mid-cycle
	task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		req <= '0;
		@(negedge clk_sys);
		d = rd_data;
		@(posedge clk_sys);
	endtask

	task automatic pause(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// window phase allows one tick either way
	task automatic chk_rate(input logic [7:0] d, input int k);
		logic [15:0] t;
		t = {8'h00, d} << k;
		n_checks++;
		if ($isunknown(d) || t <= 16'(202 - (1 << k)) || t >= 16'(202 + (1 << k))) begin
			err_total++;
			$display("unexpected at %0t: count step %h for code %0d", $time, d, k);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		pause(5);
		srst <= 1'b0;
		pause(1);
		chk({7'h0, irq}, 8'h00);
		// reset values, then write and read back each row
		foreach (rows[i]) begin
			bus_rd(rows[i].a, q);
			chk(q, 8'h00);
			bus_wr(rows[i].a, rows[i].d);
			bus_rd(rows[i].a, q);
			chk(q, rows[i].e);
			bus_wr(rows[i].a, 8'h00);
		end
		// capture: ch0 rising, ch1 falling, ch2 both, ch3 off
		bus_wr(8'hc9, 8'h39);
		ext_level <= 4'hf;
		pause(4);
		bus_rd(8'hcc, q);
		chk(q, 8'h05);
		bus_wr(8'hcc, 8'h00);
		bus_rd(8'hcc, q);
		chk(q, 8'h05);
		// fast clear: reading a capture channel drops only its own flag
		bus_wr(8'hc6, 8'h10);
		bus_rd(8'hcf, q);
		bus_rd(8'hcc, q);
		chk(q, 8'h04);
		bus_wr(8'hc6, 8'h00);
		bus_wr(8'hca, 8'h04);
		bus_rd(8'hca, q);
		chk(q, 8'h04);
		chk({7'h0, irq}, 8'h01);
		bus_wr(8'hca, 8'h02);
		bus_rd(8'hca, q);
		chk({7'h0, irq}, 8'h00);
		bus_wr(8'hcc, 8'h0f);
		ext_level <= 4'h0;
		pause(4);
		bus_rd(8'hcc, q);
		chk(q, 8'h06);
		chk({7'h0, irq}, 8'h01);
		bus_wr(8'hcc, 8'h02);
		bus_rd(8'hcc, q);
		chk(q, 8'h04);
		chk({7'h0, irq}, 8'h00);
		// each prescale code over a 202-cycle window, after the sync point
		for (int k = 0; k < 8; k++) begin
			bus_wr(8'hcb, 8'(k));
			pause(300);
			bus_rd(8'hc5, q);
			pause(200);
			bus_rd(8'hc5, q2);
			chk_rate(q2 - q, k);
		end
		// compare: ch0 toggle, ch1 clear, ch2 set, ch3 no action
		bus_wr(8'hc0, 8'h0f);
		bus_wr(8'hc8, 8'h39);
		for (int i = 0; i < 4; i++) begin
			bus_wr(8'(206 + 2 * i), 8'h00);
			bus_wr(8'(207 + 2 * i), 8'(32 * i + 32));
		end
		bus_wr(8'hcd, 8'h80);
		bus_wr(8'hca, 8'h00);
		bus_wr(8'hcb, 8'h80);
		chk({4'h0, pin_oe}, 8'h07);
		chk({7'h0, irq}, 8'h00);
		// overflow wait is long: a full 16-bit wrap at divide by one
		for (int n = 0; n < 70000 && irq !== 1'b1; n++)
			@(posedge clk_sys);
		if (irq !== 1'b1) begin
			err_total++;
			$display("unexpected at %0t: no overflow request", $time);
		end
		// modulus mode must start before the counter passes channel 3
		bus_wr(8'hcb, 8'h08);
		bus_rd(8'hcd, q);
		chk(q, 8'h80);
		chk({7'h0, irq}, 8'h00);
		bus_wr(8'hcd, 8'h80);
		bus_wr(8'hcc, 8'h0f);
		pause(300);
		bus_rd(8'hcc, q);
		chk(q, 8'h0f);
		bus_rd(8'hc5, q);
		chk({7'h0, q <= 8'h80}, 8'h01);
		bus_rd(8'hcd, q);
		chk(q, 8'h00);
		chk({5'h0, pin_out[3:1]}, 8'h02);
		// one full period of 129 counts toggles ch0 once
		p = pin_out[0];
		pause(129);
		chk({7'h0, pin_out[0]}, {7'h0, ~p});
		// masked pin 0 follows the channel 3 value bit, not its own toggle
		bus_wr(8'hc3, 8'h01);
		bus_wr(8'hc2, 8'h01);
		pause(260);
		chk({7'h0, pin_out[0]}, 8'h01);
		pause(64);
		chk({7'h0, pin_out[0]}, 8'h01);
		// request on from the running compares, then a reset in mid-run
		bus_wr(8'hca, 8'h0f);
		chk({7'h0, irq}, 8'h01);
		srst <= 1'b1;
		pause(5);
		srst <= 1'b0;
		pause(1);
		chk({pin_oe, pin_out}, 8'h00);
		chk({7'h0, irq}, 8'h00);
		bus_rd(8'hcc, q);
		chk(q, 8'h00);
		bus_rd(8'hc8, q);
		chk(q, 8'h00);
		give_verdict();
	end
endmodule
`default_nettype wire
